// ### hw/wdg_cfg.svh
`ifndef WDG_CFG_SVH
`define WDG_CFG_SVH
// Register index and layout
`define WDG_REG_CTRL        8'h2a
`define WDG_REG_OPTIONS     8'h2b
`define WDG_REG_NONE        8'h00
`define WDG_CTRL_RESET      8'h7f
`define WDG_CTRL_EN_BIT     7
`define WDG_CNT_TOP_BIT     6
`define WDG_CNT_ROLL_FROM   7'h40
`define WDG_CNT_ONE         7'h01
// Prescaler chain: single 14-bit timebase counter, one tap per 16384 ticks
`define WDG_PRESC_BITS      14
`define WDG_PRESC_ZERO      14'h0000
`define WDG_PRESC_ONE       14'h0001
`define WDG_TAP_PERIOD      14'h3fff
`define WDG_TB_2MS          2'h0
`define WDG_TB_4MS          2'h1
`define WDG_TB_10MS         2'h2
`define WDG_TB_25MS         2'h3
`define WDG_TB_OFFS_2MS     14'h0000
`define WDG_TB_OFFS_4MS     14'h1000
`define WDG_TB_OFFS_10MS    14'h2000
`define WDG_TB_OFFS_25MS    14'h3000
// Reset pulse timing
`define WDG_CLK_MHZ         25
`define WDG_RST_PULSE_US    30
`define WDG_RST_CYCLES      (`WDG_RST_PULSE_US * `WDG_CLK_MHZ)
`define WDG_RST_CNT_BITS    10
`define WDG_RST_CNT_ZERO    10'h000
`define WDG_RST_CNT_ONE     10'h001
`endif

// ### hw/wdg_pkg.sv
package wdg_pkg;
    typedef struct packed {
        logic       activation_flag;
        logic [6:0] loaded_delay_steps;
    } wdg_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wdg_bus_req_t;

    typedef enum logic [1:0] {
        WDG_RUN,
        WDG_PULSE
    } wdg_state_t;
endpackage : wdg_pkg

// ### hw/wdg_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdg_cfg.svh"
module wdg_prescaler (
    input  wire logic       clk,             // System clock
    input  wire logic       sys_rst,         // Sync reset, high
    input  wire logic       ce,              // Clock enable
    input  wire logic       osc_tick,        // One oscillator_derived_clock cycle
    input  wire logic [1:0] timebase_select, // Shared timebase choice
    output logic            tap              // One pulse per 16384 ticks
);
    logic [`WDG_PRESC_BITS-1:0] count;
    logic [`WDG_PRESC_BITS-1:0] offs;

    // Timebase shifts the phase of the shared chain
    always_comb begin
        case (timebase_select)
            `WDG_TB_2MS:  offs = `WDG_TB_OFFS_2MS;
            `WDG_TB_4MS:  offs = `WDG_TB_OFFS_4MS;
            `WDG_TB_10MS: offs = `WDG_TB_OFFS_10MS;
            default:      offs = `WDG_TB_OFFS_25MS;
        endcase
    end

    // Never cleared by counter writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= `WDG_PRESC_ZERO;
        end else if (ce && osc_tick) begin
            count <= count + `WDG_PRESC_ONE;
        end
    end

    assign tap = ce && osc_tick && ((count + offs) == `WDG_TAP_PERIOD);
endmodule : wdg_prescaler
`default_nettype wire

// ### hw/wdg_top.sv
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "wdg_cfg.svh"
module wdg_top (
    input  wire logic       clk,                      // 25 MHz clock
    input  wire logic       sys_rst,                  // Sync reset, high
    input  wire logic       ce,                       // Clock enable
    input  wire logic       osc_tick,                 // Oscillator cycle strobe
    input  wire logic [1:0] timebase_select,          // From clock controller
    input  wire logic       stop_opcode_reset_option, // Halt causes reset
    input  wire logic       hw_watchdog_option,       // Always-on mode
    input  wire logic       halt_exec,                // Halt instruction pulse
    input  wire logic [7:0] bus_addr,                 // Register address
    input  wire logic [7:0] bus_wdata,                // Write data
    input  wire logic       bus_wr,                   // Write strobe
    input  wire logic       bus_rd,                   // Read strobe
    output logic      [7:0] bus_rdata,                // Read data, next cycle
    output logic            reset_n,                  // Reset line, low active
    output logic            halt_allow                // Halt may proceed
);
    wdg_pkg::wdg_bus_req_t req;
    wdg_pkg::wdg_ctrl_t    ctrl;
    wdg_pkg::wdg_state_t   state;
    logic                        tap;
    logic                        active;
    logic                        ctrl_wr;
    logic [6:0]                  next_count;
    logic                        rollover;
    logic                        sw_reset;
    logic                        halt_reset;
    logic                        trigger;
    logic [`WDG_RST_CNT_BITS-1:0] pulse_cnt;

    assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
    assign ctrl_wr = req.wr && (req.addr == `WDG_REG_CTRL);

    // -----------------------------------------------------------------
    // Prescaler
    // -----------------------------------------------------------------
    // Shared chain, phase by timebase
    wdg_prescaler u_presc (
        .clk             (clk),
        .sys_rst         (sys_rst),
        .ce              (ce),
        .osc_tick        (osc_tick),
        .timebase_select (timebase_select),
        .tap             (tap)
    );

    // -----------------------------------------------------------------
    // Counter and enable
    // -----------------------------------------------------------------
    // Hardware option overrides enable
    assign active = hw_watchdog_option || ctrl.activation_flag;

    assign next_count = ctrl.loaded_delay_steps - `WDG_CNT_ONE;

    // Top bit falling edge while active
    assign rollover = tap && !ctrl_wr && active
                   && (ctrl.loaded_delay_steps == `WDG_CNT_ROLL_FROM);

    // Deliberate software reset
    // Sticky enable counts too: clearing the top bit while armed must reset
    assign sw_reset = ctrl_wr && (req.wdata[`WDG_CTRL_EN_BIT] || active)
                   && !req.wdata[`WDG_CNT_TOP_BIT];

    // Halt turns into reset when active or opted
    assign halt_reset = halt_exec && (active || stop_opcode_reset_option);
    assign halt_allow = !halt_reset;

    assign trigger = rollover || sw_reset || halt_reset;

    // Write wins over a same-cycle decrement
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl <= `WDG_CTRL_RESET;
        end else if (ce) begin
            if (ctrl_wr) begin
                ctrl.loaded_delay_steps <= req.wdata[6:0];
                ctrl.activation_flag <= ctrl.activation_flag
                                        | req.wdata[`WDG_CTRL_EN_BIT];
            end else if (tap) begin
                ctrl.loaded_delay_steps <= next_count;
            end
        end
    end

    // -----------------------------------------------------------------
    // Reset pulse
    // -----------------------------------------------------------------
    // Hold line low for 30 us of clk cycles
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= wdg_pkg::WDG_RUN;
            pulse_cnt <= `WDG_RST_CNT_ZERO;
        end else if (ce) begin
            case (state)
                wdg_pkg::WDG_RUN: begin
                    if (trigger) begin
                        state     <= wdg_pkg::WDG_PULSE;
                        pulse_cnt <= `WDG_RST_CNT_BITS'(`WDG_RST_CYCLES - 1);
                    end
                end
                wdg_pkg::WDG_PULSE: begin
                    if (pulse_cnt == `WDG_RST_CNT_ZERO) begin
                        state <= wdg_pkg::WDG_RUN;
                    end else begin
                        pulse_cnt <= pulse_cnt - `WDG_RST_CNT_ONE;
                    end
                end
                default: begin
                    state <= wdg_pkg::WDG_RUN;
                end
            endcase
        end
    end

    assign reset_n = (state != wdg_pkg::WDG_PULSE);

    // -----------------------------------------------------------------
    // Read port
    // -----------------------------------------------------------------
    // Side-effect free read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bus_rdata <= `WDG_REG_NONE;
        end else if (ce) begin
            if (req.rd && req.addr == `WDG_REG_CTRL) begin
                bus_rdata <= ctrl;
            end else if (req.rd && req.addr == `WDG_REG_OPTIONS) begin
                bus_rdata <= {6'h00, stop_opcode_reset_option, hw_watchdog_option};
            end else begin
                bus_rdata <= `WDG_REG_NONE;
            end
        end
    end
endmodule : wdg_top
`default_nettype wire

// ### bench/wdg_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_top_asserts (
    input wire logic       clk,                      // clock
    input wire logic       sys_rst,                  // reset
    input wire logic       ce,                       // enable
    input wire logic       stop_opcode_reset_option, // option
    input wire logic       hw_watchdog_option,       // option
    input wire logic       halt_exec,                // halt pulse
    input wire logic [7:0] bus_addr,                 // address
    input wire logic [7:0] bus_wdata,                // data
    input wire logic       bus_wr,                   // write
    input wire logic       bus_rd,                   // read
    input wire logic [7:0] bus_rdata,                // read data
    input wire logic       reset_n,                  // reset line
    input wire logic       halt_allow                // halt ok
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [9:0] low_cnt;
    wire        ctl_wr = ce && bus_wr && bus_addr == 8'h2a;
    // Counter instead of a long repetition
    always_ff @(posedge clk) begin
        // Frozen cycles do not shorten the pulse
        low_cnt <= (sys_rst || reset_n) ? 10'h000 : (ce ? low_cnt + 10'h001 : low_cnt);
    end
    sw_reset_a: assert property (ctl_wr && bus_wdata[7:6] == 2'h2 && reset_n |=> !reset_n)
        else $error("no soft reset");
    refresh_ok_a: assert property (ctl_wr && bus_wdata[6] && reset_n && !halt_exec |=> reset_n)
        else $error("reset on refresh");
    pulse_len_a: assert property ($rose(reset_n) |-> low_cnt == 10'h2ee)
        else $error("pulse length");
    halt_opt_a: assert property (halt_exec && reset_n
        && (stop_opcode_reset_option || hw_watchdog_option) |-> !halt_allow) else $error("halt let");
    halt_rst_a: assert property (ce && halt_exec && !halt_allow && reset_n |=> !reset_n)
        else $error("no halt reset");
    rd_idle_a: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
        else $error("rdata not idle");
    rst_val_a: assert property ($past(sys_rst) && bus_rd && bus_addr == 8'h2a |=> bus_rdata == 8'h7f)
        else $error("reset value");
    opt_read_a: assert property (bus_rd && bus_addr == 8'h2b |=> bus_rdata
        == {6'h00, $past(stop_opcode_reset_option), $past(hw_watchdog_option)}) else $error("options");
endmodule : wdg_top_asserts
bind wdg_top wdg_top_asserts i_wdg_top_asserts (.clk, .sys_rst, .ce, .stop_opcode_reset_option,
    .hw_watchdog_option, .halt_exec, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
    .reset_n, .halt_allow);
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wdg_cfg.svh"
module tb_top;
    logic       clk = 1'b0, sys_rst = 1'b1, halt_exec = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0;
    logic       stop_opt = 1'b0, hw_opt = 1'b0, reset_n, halt_allow;
    logic       ce = 1'b1;
    logic [1:0] timebase_select = 2'h0;
    logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata;
    int         err_total = 0, samples_checked = 0, cyc = 0, n;
    always #20 clk = ~clk;
    wdg_top i_wdg_top (.clk, .sys_rst, .ce, .osc_tick(1'b1), .timebase_select,
        .stop_opcode_reset_option(stop_opt), .hw_watchdog_option(hw_opt), .halt_exec,
        .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .reset_n, .halt_allow);
    task automatic check(input string what, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic rst();
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
    endtask : rst
    // Never called twice in a row: the strobe would be assigned twice in one step
    task automatic wr(input logic [7:0] a, d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk);
        bus_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, exp);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk);
        bus_rd <= 1'b0;
        @(posedge clk);
        check("rdata", {8'h00, bus_rdata}, {8'h00, exp});
    endtask : rdc
    task automatic watch(input logic [7:0] exp);
        for (n = 0; n == 0 || (bus_rdata !== exp && n < 20000); n++) @(posedge clk);
        check("count", {8'h00, bus_rdata}, {8'h00, exp});
    endtask : watch
    task automatic halt(input logic exp);
        halt_exec <= 1'b1;
        @(posedge clk);
        check("halt_allow", {15'h0000, halt_allow}, {15'h0000, exp});
        halt_exec <= 1'b0;
    endtask : halt
    task automatic pulse(input int lim);
        for (n = 0; reset_n !== 1'b0 && n < lim; n++) @(posedge clk);
        for (n = 0; reset_n === 1'b0 && n < 2000; n++) @(posedge clk);
        check("low_len", n[15:0], 16'(`WDG_RST_CYCLES));
    endtask : pulse
    task automatic finish_test();
        if (err_total == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    // Whole run is about four prescaler periods
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            err_total++;
            finish_test();
        end
    end
    initial begin
        rst();
        rdc(`WDG_REG_CTRL, `WDG_CTRL_RESET);
        rdc(`WDG_REG_OPTIONS, 8'h00);
        wr(8'h10, 8'h55);
        rdc(8'h10, 8'h00);
        wr(`WDG_REG_CTRL, 8'h41);
        bus_addr <= `WDG_REG_CTRL;
        bus_rd <= 1'b1;
        watch(8'h40);
        // Write eight cycles after release must not restart the chain
        check("first_step", n[15:0], {2'h0, `WDG_TAP_PERIOD} - 16'h0005);
        watch(8'h3f);
        bus_rd <= 1'b0;
        check("period", n[15:0], {2'h0, `WDG_TAP_PERIOD} + 16'h0001);
        repeat (2) @(posedge clk);
        check("reset_n", {15'h0000, reset_n}, 16'h0001);
        halt(1'b1);
        wr(`WDG_REG_CTRL, 8'hc5);
        rdc(`WDG_REG_CTRL, 8'hc5);
        wr(`WDG_REG_CTRL, 8'h45);
        rdc(`WDG_REG_CTRL, 8'hc5);
        halt(1'b0);
        pulse(4);
        rst();
        rdc(`WDG_REG_CTRL, `WDG_CTRL_RESET);
        wr(`WDG_REG_CTRL, 8'h80);
        pulse(4);
        wr(`WDG_REG_CTRL, 8'hc0);
        pulse(20000);
        stop_opt <= 1'b1;
        rst();
        rdc(`WDG_REG_OPTIONS, 8'h02);
        halt(1'b0);
        pulse(4);
        stop_opt <= 1'b0;
        hw_opt <= 1'b1;
        rst();
        halt(1'b0);
        pulse(4);
        timebase_select <= `WDG_TB_4MS;
        rst();
        // Frozen chain: the four idle cycles must not advance the phase
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        bus_addr <= `WDG_REG_CTRL;
        bus_rd <= 1'b1;
        watch(8'h7e);
        bus_rd <= 1'b0;
        check("tb_phase", n[15:0], {2'h0, `WDG_TAP_PERIOD - `WDG_TB_OFFS_4MS} + 16'h0003);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
